/* eeprom_cmd_checker.sv */
// Concurrent checks on the serial EEPROM command port pins.
`timescale 1ns/1ps
module eeprom_cmd_checker #(
   parameter int unsigned PROG_CYCLES     = 50,
   parameter int unsigned PROG_ALL_CYCLES = 600
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_select,
   input wire logic i_serial_clk,
   input wire logic i_serial_in,
   input wire logic i_word_width_strap,
   input wire logic o_serial_out,
   input wire logic o_serial_out_oe,
   input wire logic o_standby,
   input wire logic o_ready_busy_flag
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [3:0]  rise_age_q;
   logic [19:0] busy_len_q;
   // Age saturates so a stopped serial clock never wraps back into range.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) rise_age_q <= 4'hf;
      else if ($rose(i_serial_clk)) rise_age_q <= 4'h0;
      else if (rise_age_q != 4'hf) rise_age_q <= rise_age_q + 4'h1;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) busy_len_q <= 20'h0;
      else if (o_ready_busy_flag) busy_len_q <= 20'h0;
      else busy_len_q <= busy_len_q + 20'h1;
   end
   oe_release_a: assert property ($fell(i_select) |-> ##[0:6] !o_serial_out_oe)
      else $error("data out still driven after select fell");
   oe_idle_a: assert property ((!i_select) [*8] |-> !o_serial_out_oe)
      else $error("data out driven while deselected");
   oe_start_a: assert property ($rose(o_serial_out_oe) |-> $past(i_select))
      else $error("data out enabled without select");
   standby_exit_a: assert property ($rose(i_select) |-> ##[1:6] !o_standby)
      else $error("standby kept with select high");
   standby_busy_a: assert property (o_standby |-> o_ready_busy_flag)
      else $error("standby during programming");
   busy_level_a: assert property (o_serial_out_oe && !o_ready_busy_flag &&
      $past(!o_ready_busy_flag) |-> !o_serial_out)
      else $error("status high while busy");
   busy_start_a: assert property ($fell(o_ready_busy_flag) |-> $past(!i_select, 2))
      else $error("programming started without select low");
   busy_end_a: assert property ($fell(o_ready_busy_flag) |-> ##[1:1000] o_ready_busy_flag)
      else $error("programming never finished");
   busy_len_a: assert property ($rose(o_ready_busy_flag) |->
      busy_len_q >= PROG_CYCLES - 2)
      else $error("programming cycle too short");
   out_edge_a: assert property (o_serial_out_oe && $past(o_serial_out_oe) &&
      $past(o_ready_busy_flag) && $changed(o_serial_out) |-> rise_age_q <= 4'h6)
      else $error("read bit changed away from serial clock rise");
   cover property (o_serial_out_oe && o_ready_busy_flag && $changed(o_serial_out));
   cover property ($fell(o_ready_busy_flag));
   cover property (busy_len_q == 20'h1f4);
   cover property (i_select && i_serial_in && $rose(i_serial_clk));
   cover property ($rose(o_serial_out_oe) && !i_word_width_strap);
endmodule

/* eeprom_cmd_pkg.sv */
// Shared constants for the serial EEPROM command port.
package eeprom_cmd_pkg;
   localparam int unsigned CLK_HZ           = 10_000_000;
   localparam int unsigned WORD_WIDE_BITS   = 16;
   localparam int unsigned WORD_NARROW_BITS = 8;
   localparam int unsigned ADDR_MAX_BITS    = 9;
   // Density variant select: 0 smallest, 1 middle, 2 largest.
   localparam int unsigned DENSITY_DEFAULT  = 0;
   localparam logic [1:0]  OP_READ          = 2'h2;
   localparam logic [1:0]  OP_WRITE         = 2'h1;
   localparam logic [1:0]  OP_ERASE         = 2'h3;
   localparam logic [1:0]  OP_SPECIAL       = 2'h0;
   localparam logic [1:0]  SUB_ENABLE       = 2'h3;
   localparam logic [1:0]  SUB_ERASE_ALL    = 2'h2;
   localparam logic [1:0]  SUB_WRITE_ALL    = 2'h1;
   localparam logic [1:0]  SUB_DISABLE      = 2'h0;
   // Self-timed programming cycle, shortened by a top parameter in simulation.
   localparam int unsigned PROG_TIME_US     = 4000;
   localparam int unsigned PROG_ALL_TIME_US = 16000;
   localparam int unsigned PROG_CYCLES      = PROG_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PROG_ALL_CYCLES  = PROG_ALL_TIME_US * (CLK_HZ / 1_000_000);
   localparam logic [15:0] ERASED_WORD      = 16'hffff;
endpackage

/* eeprom_cmd_port.sv */
// Serial EEPROM command front end with word array and self-timed programming.
`timescale 1ns/1ps

// Overview of operation
// (R01) Start is first rising clock with select and serial input both high.
// (R02) Nothing executes before a start condition is recognised.
// (R03) Instruction executes only after all its opcode, address, data bits.
// (R04) After the last bit, clock and input are ignored until new start.
// (R05) Input bits are sampled on each rising serial clock edge.
// (R06) Strap high selects 16-bit words, low selects 8-bit words and wider address.
// (R07) Output is high impedance except read data or busy status.
// (R08) Status polling drives low while busy, high when ready.
// (R09) Output goes high impedance when select falls.
// (R10) Standby ends as soon as select is high.
// (R11) Programming is disabled after power-up until enable command.
// (R12) Read shifts out a dummy zero then the addressed word.
// (R13) Read output bits change on the rising serial clock edge.
// (R14) Continued clocking after a read word streams the next address.
// (R15) Opcode 10 read, 01 write, 11 erase; 00 uses top address bits.
// (R16) Address width depends on density and strap, with optional leading don't-care.
// (R17) Write and write-all take a data word most significant bit first.
// (R18) Master supplies the tabulated clock count per instruction.
// (R19) Enable and disable commands gate all erase and write operations.
// (R20) Enable persists until disable or power loss; reads ignore enable state.
// (R21) Select falling after an erase or write starts self-timed programming.
// (R22) Erase sets the word to ones, erase-all sets the array to ones.
// (R23) Select low holds the control logic in reset.
// (R24) Programming instructions while disabled are ignored with no busy status.
// (R25) Sequential read wraps from the top word to address zero.
module eeprom_cmd_port #(
   parameter int unsigned DENSITY         = eeprom_cmd_pkg::DENSITY_DEFAULT,
   parameter int unsigned PROG_CYCLES     = eeprom_cmd_pkg::PROG_CYCLES,
   parameter int unsigned PROG_ALL_CYCLES = eeprom_cmd_pkg::PROG_ALL_CYCLES
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_select,
   input  wire logic i_serial_clk,
   input  wire logic i_serial_in,
   input  wire logic i_word_width_strap,
   output logic      o_serial_out,
   output logic      o_serial_out_oe,
   output logic      o_standby,
   output logic      o_ready_busy_flag
);
   localparam int unsigned WW = eeprom_cmd_pkg::WORD_WIDE_BITS;
   localparam int unsigned WN = eeprom_cmd_pkg::WORD_NARROW_BITS;
   localparam int unsigned AM = eeprom_cmd_pkg::ADDR_MAX_BITS;
   localparam int unsigned DEPTH = 1 << AM;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_READ, ST_DONE
   } seq_state_t;

   // Address field length in bits, including any leading don't-care bit.
   function automatic logic [3:0] addr_len(input logic wide);
      case (DENSITY)
         0:       addr_len = wide ? 4'h6 : 4'h7;
         default: addr_len = wide ? 4'h8 : 4'h9;
      endcase
   endfunction

   // Number of real address bits, which sets the wrap point.
   function automatic logic [3:0] addr_bits(input logic wide);
      case (DENSITY)
         0:       addr_bits = wide ? 4'h6 : 4'h7;
         1:       addr_bits = wide ? 4'h7 : 4'h8;
         default: addr_bits = wide ? 4'h8 : 4'h9;
      endcase
   endfunction

   // The array is kept in bytes so that both organisations share it.
   logic [7:0] mem [0:DEPTH-1];

   logic       rst_s1_q, rst_n_q;
   logic [1:0] cs_s_q, sck_s_q, din_s_q, strap_s_q;
   logic       cs_d1_q, sck_d1_q;
   wire        cs     = cs_s_q[1];
   wire        sck    = sck_s_q[1];
   wire        din    = din_s_q[1];
   wire        sck_up = sck & ~sck_d1_q;
   wire        cs_up  = cs & ~cs_d1_q;
   wire        cs_dn  = ~cs & cs_d1_q;

   seq_state_t state_q;
   logic [4:0] cnt_q;
   logic [1:0] op_q;
   logic [AM-1:0] addr_q;
   logic [15:0] data_q;
   logic [15:0] rd_q;
   logic        wide_q;
   logic        enable_q;
   logic        pend_q;
   logic [1:0]  pend_kind_q;
   logic [AM-1:0] pend_addr_q;
   logic [15:0] pend_data_q;
   logic        pend_wide_q;
   logic        busy_q;
   logic        poll_q;
   logic [31:0] timer_q;
   logic [AM:0] sweep_q;
   logic        sweeping_q;

   localparam logic [1:0] K_ERASE = 2'h0;
   localparam logic [1:0] K_WRITE = 2'h1;
   localparam logic [1:0] K_ERASE_ALL_CMD  = 2'h2;
   localparam logic [1:0] K_WRITE_ALL_CMD  = 2'h3;

   wire [AM-1:0] addr_mask = AM'((10'h001 << addr_bits(wide_q)) - 10'h001);
   // Masking drops the don't-care bit that some variants send ahead of the address.
   wire [AM-1:0] addr_eff  = addr_q & addr_mask;
   wire [AM-1:0] byte_base = wide_q ? AM'({addr_eff, 1'b0}) : addr_eff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // Pins cross into the system clock through two flops before use.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cs_s_q    <= 2'h0;
         sck_s_q   <= 2'h0;
         din_s_q   <= 2'h0;
         strap_s_q <= 2'h0;
         cs_d1_q   <= 1'b0;
         sck_d1_q  <= 1'b0;
      end else begin
         cs_s_q    <= {cs_s_q[0], i_select};
         sck_s_q   <= {sck_s_q[0], i_serial_clk};
         din_s_q   <= {din_s_q[0], i_serial_in};
         strap_s_q <= {strap_s_q[0], i_word_width_strap};
         cs_d1_q   <= cs;
         sck_d1_q  <= sck;
      end
   end

   // Command sequencer.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_IDLE;
         cnt_q   <= 5'h00;
         op_q    <= 2'h0;
         addr_q  <= '0;
         data_q  <= 16'h0000;
         rd_q    <= 16'h0000;
         wide_q  <= 1'b0;
      end else if (!cs) begin
         state_q <= ST_IDLE; // [R23]
         cnt_q   <= 5'h00;
      end else if (sck_up) begin // [R05]
         case (state_q)
            ST_IDLE: if (din) begin // [R01] [R02]
               state_q <= ST_OPCODE;
               cnt_q   <= 5'h00;
               wide_q  <= strap_s_q[1]; // [R06]
               // Clearing here keeps bits of the last address out of a shorter field.
               addr_q  <= '0;
            end
            ST_OPCODE: begin
               op_q  <= {op_q[0], din}; // [R15]
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == 5'h01) begin
                  state_q <= ST_ADDR;
                  cnt_q   <= 5'h00;
               end
            end
            ST_ADDR: begin
               addr_q <= {addr_q[AM-2:0], din}; // [R16]
               cnt_q  <= cnt_q + 5'h01;
               if (cnt_q == 5'(addr_len(wide_q) - 4'h1)) begin
                  cnt_q <= 5'h00;
                  // With one address bit still to come, the top two bits sit just below it.
                  if (op_q == eeprom_cmd_pkg::OP_READ) begin
                     state_q <= ST_READ;
                     rd_q    <= 16'h0000; // [R12]
                  end else if (op_q == eeprom_cmd_pkg::OP_WRITE ||
                               (op_q == eeprom_cmd_pkg::OP_SPECIAL &&
                                addr_len(wide_q) >= 4'h2 &&
                                addr_q[4'(addr_len(wide_q) - 4'h2) -: 2] ==
                                eeprom_cmd_pkg::SUB_WRITE_ALL)) begin
                     state_q <= ST_DATA;
                  end else begin
                     state_q <= ST_DONE; // [R03]
                  end
               end
            end
            ST_DATA: begin
               data_q <= {data_q[14:0], din}; // [R17]
               cnt_q  <= cnt_q + 5'h01;
               if (cnt_q == (wide_q ? 5'(WW - 1) : 5'(WN - 1))) begin
                  state_q <= ST_DONE; // [R03]
               end
            end
            ST_READ: begin
               // Bit zero of the counter run is the dummy zero.
               cnt_q <= cnt_q + 5'h01; // [R13]
               if (cnt_q == 5'h00) begin
                  rd_q <= wide_q ? {mem[byte_base], mem[byte_base + AM'(1)]}
                                 : {mem[addr_eff], 8'h00};
               end else begin
                  rd_q <= {rd_q[14:0], 1'b0};
               end
               if (cnt_q == (wide_q ? 5'(WW) : 5'(WN))) begin
                  // Next word streams straight after the last bit.
                  addr_q <= (addr_q + AM'(1)) & addr_mask; // [R14] [R25]
                  cnt_q  <= 5'h01;
                  rd_q   <= wide_q ? {mem[AM'({(addr_q + AM'(1)) & addr_mask, 1'b0})],
                                      mem[AM'({(addr_q + AM'(1)) & addr_mask, 1'b1})]}
                                   : {mem[(addr_q + AM'(1)) & addr_mask], 8'h00};
               end
            end
            ST_DONE: state_q <= ST_DONE; // [R04]
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Latch a complete programming instruction; enable and disable act at once.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         enable_q    <= 1'b0; // [R11]
         pend_q      <= 1'b0;
         pend_kind_q <= K_ERASE;
         pend_addr_q <= '0;
         pend_data_q <= 16'h0000;
         pend_wide_q <= 1'b0;
      end else if (state_q == ST_DONE && cs_dn) begin
         pend_q <= 1'b0;
      end else if (cs && sck_up && state_q != ST_DONE && state_q != ST_IDLE) begin
         pend_q <= 1'b0;
      end else if (cs && state_q == ST_DONE && !pend_q && !busy_q) begin
         // The masked address keeps a don't-care bit from choosing the wrong byte.
         pend_addr_q <= addr_eff;
         pend_data_q <= data_q;
         pend_wide_q <= wide_q;
         if (op_q == eeprom_cmd_pkg::OP_SPECIAL) begin
            case (addr_q[4'(addr_len(wide_q) - 4'h1) -: 2])
               eeprom_cmd_pkg::SUB_ENABLE:    enable_q <= 1'b1; // [R19] [R20]
               eeprom_cmd_pkg::SUB_DISABLE:   enable_q <= 1'b0; // [R19] [R20]
               eeprom_cmd_pkg::SUB_ERASE_ALL: begin
                  pend_kind_q <= K_ERASE_ALL_CMD;
                  pend_q      <= enable_q; // [R24]
               end
               default: begin
                  pend_kind_q <= K_WRITE_ALL_CMD;
                  pend_q      <= enable_q; // [R24]
               end
            endcase
         end else if (op_q != eeprom_cmd_pkg::OP_READ) begin
            pend_kind_q <= (op_q == eeprom_cmd_pkg::OP_WRITE) ? K_WRITE : K_ERASE;
            pend_q      <= enable_q; // [R24]
         end
      end
   end

   // Self-timed programming; runs on regardless of select once begun.
   wire start_prog = pend_q && cs_dn && state_q == ST_DONE; // [R21]
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         busy_q     <= 1'b0;
         timer_q    <= 32'h0000_0000;
         sweep_q    <= '0;
         sweeping_q <= 1'b0;
      end else if (start_prog) begin
         busy_q  <= 1'b1;
         timer_q <= (pend_kind_q[1]) ? 32'(PROG_ALL_CYCLES) : 32'(PROG_CYCLES);
         if (pend_kind_q[1]) begin
            sweeping_q <= 1'b1;
            sweep_q    <= '0;
         end else begin
            if (pend_wide_q) begin
               mem[AM'({pend_addr_q, 1'b0})] <= pend_kind_q[0] ? pend_data_q[15:8] : 8'hff;
               mem[AM'({pend_addr_q, 1'b1})] <= pend_kind_q[0] ? pend_data_q[7:0] : 8'hff;
            end else begin
               mem[pend_addr_q] <= pend_kind_q[0] ? pend_data_q[7:0] : 8'hff; // [R22]
            end
         end
      end else begin
         // The array sweep for the all-word cycles takes one byte a clock.
         if (sweeping_q) begin
            mem[sweep_q[AM-1:0]] <= !pend_kind_q[0] ? eeprom_cmd_pkg::ERASED_WORD[7:0] // [R22]
                                  : (!pend_wide_q ? pend_data_q[7:0]
                                  : (sweep_q[0] ? pend_data_q[7:0] : pend_data_q[15:8]));
            sweep_q <= sweep_q + (AM+1)'(1);
            if (sweep_q == (AM+1)'(DEPTH - 1)) begin
               sweeping_q <= 1'b0;
            end
         end
         if (busy_q) begin
            if (timer_q <= 32'h0000_0001) begin
               busy_q <= 1'b0;
            end
            timer_q <= timer_q - 32'h0000_0001;
         end
      end
   end

   // Status is shown only when select rises during a started program cycle.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         poll_q <= 1'b0;
      end else if (!cs) begin
         poll_q <= 1'b0;
      end else if (cs_up && busy_q) begin
         poll_q <= 1'b1;
      end else if (sck_up && din && state_q == ST_IDLE) begin
         poll_q <= 1'b0; // A new start releases the status line.
      end
   end

   // Output stage, all from flops.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_serial_out      <= 1'b0;
         o_serial_out_oe   <= 1'b0;
         o_standby         <= 1'b1;
         o_ready_busy_flag <= 1'b1;
      end else begin
         o_standby         <= ~cs && ~busy_q; // [R10]
         o_ready_busy_flag <= ~busy_q;
         if (!cs) begin
            o_serial_out_oe <= 1'b0; // [R09]
            o_serial_out    <= 1'b0;
         end else if (state_q == ST_READ) begin
            o_serial_out_oe <= 1'b1; // [R07]
            o_serial_out    <= (cnt_q == 5'h00) ? 1'b0 : rd_q[15]; // [R12]
         end else if (poll_q) begin
            o_serial_out_oe <= 1'b1; // [R07]
            o_serial_out    <= ~busy_q; // [R08]
         end else begin
            o_serial_out_oe <= 1'b0; // [R07]
            o_serial_out    <= 1'b0;
         end
      end
   end
endmodule

/* serial_master_model.sv */
// Serial bus master model that frames instructions on select, clock and data in.
`timescale 1ns/1ps
module serial_master_model (
   input  wire logic i_clk,
   input  wire logic i_data_line,
   output logic      o_select,
   output logic      o_serial_clk,
   output logic      o_serial_in
);
   initial begin
      o_select     = 1'b0;
      o_serial_clk = 1'b0;
      o_serial_in  = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Select is held low between instructions and dropped after the last bit.
   task automatic sel(input logic v, input int n);
      o_select = v;
      cyc(n);
   endtask
   // Bits go out MSB first, each set up a half period before its rise.
   task automatic xfer(input logic [31:0] bits, input int n, output logic [31:0] rd);
      rd = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         o_serial_in = bits[i];
         cyc(4);
         rd = {rd[30:0], i_data_line};
         o_serial_clk = 1'b1;
         cyc(4);
         o_serial_clk = 1'b0;
      end
      // A released data line does not keep showing the last bit.
      o_serial_in = ~o_serial_in;
      cyc(1);
   endtask
endmodule

/* testbench.sv */
// Self-checking bench for the serial EEPROM command port.
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [1:0]  op;
      logic [5:0]  a;
      logic [15:0] d;
      logic [15:0] e;
   } row_t;
   localparam row_t ROWS [13] = '{
      '{2'h1, 6'h05, 16'h1234, 16'h0}, '{2'h0, 6'h30, 16'h0, 16'h0},
      '{2'h0, 6'h20, 16'h0, 16'h1}, '{2'h2, 6'h14, 16'h0, 16'hffff},
      '{2'h0, 6'h10, 16'h0f0f, 16'h1}, '{2'h2, 6'h03, 16'h0, 16'h0f0f},
      '{2'h1, 6'h3f, 16'ha5c3, 16'h1}, '{2'h1, 6'h00, 16'h5a3c, 16'h1},
      '{2'h3, 6'h07, 16'h0, 16'h1}, '{2'h2, 6'h07, 16'h0, 16'hffff},
      '{2'h0, 6'h00, 16'h0, 16'h0}, '{2'h1, 6'h07, 16'h1111, 16'h0},
      '{2'h2, 6'h07, 16'h0, 16'hffff}};
   logic        clk;
   logic        rst_n;
   logic        strap;
   wire         sel;
   wire         sclk;
   wire         sdin;
   logic        dout;
   logic        oe;
   logic        standby;
   logic        ready;
   logic [31:0] rd;
   int          n_errors;
   int          num_checks;
   int          cycles;
   // The data line has a pull-up, so a released line reads high.
   wire         data_line = oe ? dout : 1'b1;
   eeprom_cmd_port #(.PROG_CYCLES(50), .PROG_ALL_CYCLES(600)) eeprom_cmd_port_inst (
      .i_clk(clk), .i_rst_n(rst_n), .i_select(sel), .i_serial_clk(sclk),
      .i_serial_in(sdin), .i_word_width_strap(strap), .o_serial_out(dout),
      .o_serial_out_oe(oe), .o_standby(standby), .o_ready_busy_flag(ready));
   serial_master_model serial_master_model_inst (
      .i_clk(clk), .i_data_line(data_line), .o_select(sel), .o_serial_clk(sclk),
      .o_serial_in(sdin));
   task automatic test_done();
      if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [8:0] cmd(input logic [1:0] op, input logic [5:0] a);
      return {1'b1, op, a};
   endfunction
   task automatic run(input row_t r);
      int w;
      serial_master_model_inst.sel(1'b1, 2);
      if (r.op == eeprom_cmd_pkg::OP_READ) begin
         serial_master_model_inst.xfer({23'h0, cmd(r.op, r.a)}, 9, rd);
         serial_master_model_inst.xfer(32'h0, 17, rd);
         check("read word", rd[16:0], {1'b0, r.e});
      end else begin
         if (r.op == eeprom_cmd_pkg::OP_WRITE || r.a[5:4] == eeprom_cmd_pkg::SUB_WRITE_ALL &&
             r.op == eeprom_cmd_pkg::OP_SPECIAL)
            serial_master_model_inst.xfer({7'h0, cmd(r.op, r.a), r.d}, 25, rd);
         else serial_master_model_inst.xfer({23'h0, cmd(r.op, r.a)}, 9, rd);
         serial_master_model_inst.sel(1'b0, 8);
         serial_master_model_inst.sel(1'b1, 6);
         check("status drive", oe, r.e[0]);
         if (r.e[0] === 1'b1) begin
            check("busy level", dout, 1'b0);
            w = 0;
            while (dout !== 1'b1 && w < 1500) begin
               serial_master_model_inst.cyc(1);
               w++;
            end
            check("ready level", dout, 1'b1);
         end
      end
      serial_master_model_inst.sel(1'b0, 8);
      check("released", oe, 1'b0);
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      rst_n = 1'b0;
      strap = 1'b1;
      serial_master_model_inst.cyc(4);
      rst_n = 1'b1;
      serial_master_model_inst.cyc(8);
      foreach (ROWS[i]) run(ROWS[i]);
      // Narrow organisation reads byte 1, the low half of word 0.
      strap = 1'b0;
      serial_master_model_inst.sel(1'b1, 2);
      serial_master_model_inst.xfer({22'h0, 1'b1, 2'h2, 7'h01}, 10, rd);
      serial_master_model_inst.xfer(32'h0, 9, rd);
      check("narrow read", rd[8:0], 9'h03c);
      serial_master_model_inst.sel(1'b0, 8);
      strap = 1'b1;
      // Leading zeros before the start bit, then a stream across the top address.
      serial_master_model_inst.sel(1'b1, 6);
      check("standby", standby, 1'b0);
      serial_master_model_inst.xfer({19'h0, 4'h0, cmd(2'h2, 6'h3f)}, 13, rd);
      serial_master_model_inst.xfer(32'h0, 17, rd);
      check("top word", rd[16:0], 17'h0a5c3);
      serial_master_model_inst.xfer(32'h0, 16, rd);
      check("wrapped word", rd[15:0], 16'h5a3c);
      serial_master_model_inst.sel(1'b0, 8);
      // Bits after a complete enable are ignored, so the trailing disable has no effect.
      serial_master_model_inst.sel(1'b1, 2);
      serial_master_model_inst.xfer({14'h0, cmd(2'h0, 6'h30), cmd(2'h0, 6'h00)}, 18, rd);
      serial_master_model_inst.sel(1'b0, 8);
      run('{2'h1, 6'h3f, 16'h0001, 16'h1});
      run('{2'h2, 6'h3f, 16'h0, 16'h0001});
      // Reset in mid-read stops the output drive at once.
      serial_master_model_inst.sel(1'b1, 2);
      serial_master_model_inst.xfer({23'h0, cmd(2'h2, 6'h00)}, 9, rd);
      rst_n = 1'b0;
      serial_master_model_inst.sel(1'b0, 4);
      check("reset drive", {oe, standby, ready}, 3'h3);
      rst_n = 1'b1;
      serial_master_model_inst.cyc(8);
      // Reset drops the enable, so a write is refused while the old word still reads back.
      run('{2'h1, 6'h3f, 16'h7777, 16'h0});
      run('{2'h2, 6'h3f, 16'h0, 16'h0001});
      test_done();
   end
endmodule
bind eeprom_cmd_port eeprom_cmd_checker #(
   .PROG_CYCLES(PROG_CYCLES), .PROG_ALL_CYCLES(PROG_ALL_CYCLES)) eeprom_cmd_checker_inst (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_select(i_select), .i_serial_clk(i_serial_clk),
   .i_serial_in(i_serial_in), .i_word_width_strap(i_word_width_strap),
   .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
   .o_standby(o_standby), .o_ready_busy_flag(o_ready_busy_flag));
